// file: common/lscd_pkg.sv
// Purpose: shared constants and types for the display command decoder
// Assumes: one 200 MHz clock, byte-wide command and reply streams
// Notes: memory map of the byte store and the APB register map live here
package lscd_pkg;
	// command codes taken by this block
	localparam logic [7:0] CMD_SAVE_BOOT = 8'h04;
	localparam logic [7:0] CMD_LINE2 = 8'h08;
	localparam logic [7:0] CMD_GLYPH = 8'h09;
	localparam logic [7:0] CMD_READ_MEM = 8'h0A;
	localparam logic [7:0] CMD_CURSOR_POS = 8'h0B;
	localparam logic [7:0] CMD_CURSOR_STYLE = 8'h0C;
	localparam logic [7:0] CMD_CONTRAST = 8'h0D;
	localparam logic [7:0] CMD_BACKLIGHT = 8'h0E;
	localparam logic [7:0] CMD_DEV_INFO = 8'h12;
	localparam logic [7:0] CMD_TEMP_MASK = 8'h13;
	// reply type bits on top of the echoed low six bits
	localparam logic [1:0] RSP_ACK = 2'h1;
	localparam logic [1:0] RSP_ERR = 2'h3;
	// payload lengths
	localparam logic [4:0] LEN_NONE = 5'h00;
	localparam logic [4:0] LEN_ONE = 5'h01;
	localparam logic [4:0] LEN_TWO = 5'h02;
	localparam logic [4:0] LEN_MASK = 5'h04;
	localparam logic [4:0] LEN_GLYPH = 5'h09;
	localparam logic [4:0] LEN_LINE = 5'h10;
	localparam logic [4:0] LEN_READ_RSP = 5'h09;
	localparam int PAY_DEPTH = 16;
	// value limits
	localparam logic [7:0] MAX_GLYPH_SLOT = 8'h07;
	localparam logic [7:0] GLYPH_ROW_MASK = 8'h3F;
	localparam logic [7:0] MAX_COL = 8'h0F;
	localparam logic [7:0] MAX_ROW = 8'h01;
	localparam logic [7:0] MAX_STYLE = 8'h03;
	localparam logic [7:0] MAX_CONTRAST_LEGACY = 8'hC8;
	localparam logic [7:0] MAX_DEV_IDX = 8'h1F;
	// byte store map: chars, glyph rows, ROM records
	localparam int MEM_AW = 9;
	localparam logic [8:0] LINE2_BASE = 9'h010;
	localparam logic [8:0] GLYPH_BASE = 9'h040;
	localparam logic [8:0] ROM_BASE = 9'h100;
	localparam logic [3:0] LINE_LAST = 4'hF;
	localparam logic [3:0] GLYPH_LAST = 4'h7;
	localparam logic [3:0] RSP_LAST = 4'h8;
	// APB register byte offsets
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_SETTINGS = 12'h008;
	localparam logic [11:0] ADDR_TEMP_MASK = 12'h00C;
	localparam logic [11:0] ADDR_PRESENT = 12'h010;
	localparam logic [11:0] ADDR_THERMO = 12'h014;
	// values after reset
	localparam logic RST_CMD_EN = 1'b1;
	localparam logic [7:0] RST_CONTRAST = 8'h20;
	localparam logic [7:0] RST_BACKLIGHT = 8'h64;
	// report period
	localparam int REPORT_PERIOD_MS = 1000;
	localparam int CLOCK_KHZ = 200000;
	localparam int REPORT_CYCLES = REPORT_PERIOD_MS * CLOCK_KHZ;
	// sequencer states
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_RECV = 3'h1,
		S_EXEC = 3'h2,
		S_WRITE = 3'h3,
		S_HDR = 3'h4,
		S_DATA = 3'h5
	} lscd_state_t;
endpackage

// file: rtl/lscd_byte_ram.sv
// Purpose: byte store for display chars, glyph rows and bus ROM records
// Assumes: one write and one read port on the same clock
// Notes: read data come out of a register, one cycle after the address
module lscd_byte_ram #(
	parameter int AW = 9,
	parameter int DW = 8
) (
	// clock and freeze
	input wire logic clk,
	input wire logic en,
	// write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// read port
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [2**AW];

	if (AW < 9 || DW != 8) begin : g_check
		$error("byte store needs at least 9 address bits and 8 data bits");
	end

	// no reset on the array: contents are defined by writes only
	always_ff @(posedge clk) begin
		if (en && we) begin
			mem[waddr] <= wdata;
		end
	end

	// registered read port
	always_ff @(posedge clk) begin
		if (en) begin
			rdata <= mem[raddr];
		end
	end
endmodule

// file: rtl/lscd_decoder.sv
// Purpose: decodes display and sensor command packets, answers with replies
// Assumes: framing and checks done upstream; CE high for normal running
// Notes: replies stream out at one byte per cycle with no back-pressure
// How it works
// - code 0x08 with 16 bytes fills lower row, then empty ack 0x48
// - code 0x09 with 9 bytes: slot 0-7 then eight new glyph rows
// - glyph rows keep six bits, first byte top row, eighth bottom
// - code 0x0A replies address code then 8 bytes of display memory
// - code 0x0B moves cursor to column 0-15, row 0-1, then acks
// - code 0x0C picks one of four cursor styles, acked with 0x4C
// - contrast 0x0D with one byte takes 0-200 legacy values, acks 0x4D
// - contrast with two bytes ignores first, sets fine value from second
// - backlight 0x0E with one byte sets display and keypad alike
// - backlight with two bytes sets display then keypad separately
// - bus records found at power-up are kept by device number
// - code 0x12 index 0-31 replies 0x52: index plus eight ROM bytes
// - first returned ROM byte is the family code
// - only the two thermometer families are eligible for reports
// - code 0x13 four bytes form mask, bit n byte k is 8k+n, ack 0x53
// - enabled sensors get a conversion and report once per second
// - settings are saved by code 0x04 and restored at power-up; here 0x04 only pulses BOOT_SAVE and reset loads fixed defaults
// - replies echo low six type bits; normal acks add 0x40
//
// The implementer's own choices: the placing of the registers and the APB slave port.
module lscd_decoder #(
	parameter int REPORT_CYCLES = lscd_pkg::REPORT_CYCLES,
	parameter logic [7:0] THERMO_FAMILY_A = 8'hA1, // arbitrary family value
	parameter logic [7:0] THERMO_FAMILY_B = 8'hA2 // arbitrary family value
) (
	// clock, reset, freeze
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic CE,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// command stream
	input wire logic CMD_START,
	input wire logic [7:0] CMD_TYPE,
	input wire logic [4:0] CMD_LEN,
	input wire logic CMD_DATA_VALID,
	input wire logic [7:0] CMD_DATA,
	output logic CMD_READY,
	// reply stream
	output logic RSP_START,
	output logic [7:0] RSP_TYPE,
	output logic [4:0] RSP_LEN,
	output logic RSP_DATA_VALID,
	output logic [7:0] RSP_DATA,
	// single_wire_bus enumeration records
	input wire logic ENUM_WE,
	input wire logic [4:0] ENUM_IDX,
	input wire logic [2:0] ENUM_SEL,
	input wire logic [7:0] ENUM_DATA,
	// display settings
	output logic [7:0] CONTRAST,
	output logic CONTRAST_FINE,
	output logic [7:0] LCD_BL,
	output logic [7:0] KEY_BL,
	output logic [3:0] CURSOR_COL,
	output logic CURSOR_ROW,
	output logic [1:0] CURSOR_STYLE,
	output logic BOOT_SAVE,
	// temperature requests
	output logic TEMP_REQ,
	output logic [4:0] TEMP_IDX
);
	lscd_pkg::lscd_state_t state, next_state;
	logic [7:0] cur_type;
	logic [4:0] cur_len;
	logic [4:0] rcnt;
	logic [7:0] pay [lscd_pkg::PAY_DEPTH];
	logic [3:0] wcnt;
	logic [3:0] dcnt;
	logic exec_ok;
	logic [4:0] exec_rlen;
	logic [4:0] rsp_len;
	logic cmd_en;
	logic [7:0] err_cnt;
	logic [31:0] temp_mask;
	logic [31:0] present;
	logic [31:0] thermo;
	logic [31:0] pend;
	logic [31:0] tick_cnt;
	logic mem_we;
	logic [8:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic [8:0] mem_raddr;
	logic [8:0] read_base;
	logic [7:0] mem_rdata;
	logic is_write_cmd;
	logic [3:0] wlast;

	if (REPORT_CYCLES < 40) begin : g_check
		$error("report period too short to drain all sensor requests");
	end

	// lowest set bit of the pending sensor set
	function automatic logic [4:0] first_set(input logic [31:0] v);
		logic [4:0] idx;
		idx = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				idx = 5'(i);
			end
		end
		return idx;
	endfunction

	// legality of the held command and its reply length
	always_comb begin
		exec_ok = 1'b0;
		exec_rlen = lscd_pkg::LEN_NONE;
		case (cur_type)
			lscd_pkg::CMD_SAVE_BOOT: exec_ok = cur_len == lscd_pkg::LEN_NONE;
			lscd_pkg::CMD_LINE2: exec_ok = cur_len == lscd_pkg::LEN_LINE;
			lscd_pkg::CMD_GLYPH: begin
				exec_ok = cur_len == lscd_pkg::LEN_GLYPH && pay[0] <= lscd_pkg::MAX_GLYPH_SLOT;
			end
			lscd_pkg::CMD_READ_MEM: begin
				exec_ok = cur_len == lscd_pkg::LEN_ONE;
				exec_rlen = lscd_pkg::LEN_READ_RSP;
			end
			lscd_pkg::CMD_CURSOR_POS: begin
				exec_ok = cur_len == lscd_pkg::LEN_TWO && pay[0] <= lscd_pkg::MAX_COL
					&& pay[1] <= lscd_pkg::MAX_ROW;
			end
			lscd_pkg::CMD_CURSOR_STYLE: begin
				exec_ok = cur_len == lscd_pkg::LEN_ONE && pay[0] <= lscd_pkg::MAX_STYLE;
			end
			lscd_pkg::CMD_CONTRAST: begin
				exec_ok = (cur_len == lscd_pkg::LEN_ONE && pay[0] <= lscd_pkg::MAX_CONTRAST_LEGACY)
					|| cur_len == lscd_pkg::LEN_TWO;
			end
			lscd_pkg::CMD_BACKLIGHT: begin
				exec_ok = cur_len == lscd_pkg::LEN_ONE || cur_len == lscd_pkg::LEN_TWO;
			end
			lscd_pkg::CMD_DEV_INFO: begin
				exec_ok = cur_len == lscd_pkg::LEN_ONE && pay[0] <= lscd_pkg::MAX_DEV_IDX;
				exec_rlen = lscd_pkg::LEN_READ_RSP;
			end
			lscd_pkg::CMD_TEMP_MASK: exec_ok = cur_len == lscd_pkg::LEN_MASK;
			default: exec_ok = 1'b0; // reserved or foreign codes
		endcase
		if (!exec_ok) begin
			exec_rlen = lscd_pkg::LEN_NONE;
		end
	end

	assign is_write_cmd = cur_type == lscd_pkg::CMD_LINE2 || cur_type == lscd_pkg::CMD_GLYPH;
	assign wlast = (cur_type == lscd_pkg::CMD_LINE2) ? lscd_pkg::LINE_LAST : lscd_pkg::GLYPH_LAST;

	// sequencer next state; memory writes yield to enumeration
	always_comb begin
		next_state = state;
		unique case (state)
			lscd_pkg::S_IDLE: begin
				if (CMD_START && CMD_READY) begin
					next_state = (CMD_LEN == lscd_pkg::LEN_NONE) ? lscd_pkg::S_EXEC : lscd_pkg::S_RECV;
				end
			end
			lscd_pkg::S_RECV: begin
				if (CMD_DATA_VALID && CMD_READY && 5'(rcnt + 5'h01) == cur_len) begin
					next_state = lscd_pkg::S_EXEC;
				end
			end
			lscd_pkg::S_EXEC: begin
				next_state = (exec_ok && is_write_cmd) ? lscd_pkg::S_WRITE : lscd_pkg::S_HDR;
			end
			lscd_pkg::S_WRITE: begin
				if (!ENUM_WE && wcnt == wlast) begin
					next_state = lscd_pkg::S_HDR;
				end
			end
			lscd_pkg::S_HDR: begin
				next_state = (rsp_len == lscd_pkg::LEN_NONE) ? lscd_pkg::S_IDLE : lscd_pkg::S_DATA;
			end
			lscd_pkg::S_DATA: begin
				if (dcnt == lscd_pkg::RSP_LAST) begin
					next_state = lscd_pkg::S_IDLE;
				end
			end
			default: next_state = lscd_pkg::S_IDLE;
		endcase
	end

	// state, ready and command capture
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state <= lscd_pkg::S_IDLE;
			CMD_READY <= 1'b0;
			cur_type <= 8'h00;
			cur_len <= 5'h00;
			rcnt <= 5'h00;
		end else if (CE) begin
			state <= next_state;
			CMD_READY <= cmd_en && (next_state == lscd_pkg::S_IDLE || next_state == lscd_pkg::S_RECV);
			if (state == lscd_pkg::S_IDLE && CMD_START && CMD_READY) begin
				cur_type <= CMD_TYPE;
				cur_len <= CMD_LEN;
				rcnt <= 5'h00;
			end else if (state == lscd_pkg::S_RECV && CMD_DATA_VALID && CMD_READY) begin
				rcnt <= 5'(rcnt + 5'h01);
			end
		end
	end

	// payload bytes beyond sixteen are counted but dropped
	always_ff @(posedge CLOCK) begin
		if (CE && state == lscd_pkg::S_RECV && CMD_DATA_VALID && CMD_READY && !rcnt[4]) begin
			pay[rcnt[3:0]] <= CMD_DATA;
		end
	end

	// settings applied only by a legal command
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			CONTRAST <= lscd_pkg::RST_CONTRAST;
			CONTRAST_FINE <= 1'b0;
			LCD_BL <= lscd_pkg::RST_BACKLIGHT;
			KEY_BL <= lscd_pkg::RST_BACKLIGHT;
			CURSOR_COL <= 4'h0;
			CURSOR_ROW <= 1'b0;
			CURSOR_STYLE <= 2'h0;
			temp_mask <= 32'h00000000;
			BOOT_SAVE <= 1'b0;
		end else if (CE) begin
			BOOT_SAVE <= state == lscd_pkg::S_EXEC && exec_ok
				&& cur_type == lscd_pkg::CMD_SAVE_BOOT;
			if (state == lscd_pkg::S_EXEC && exec_ok) begin
				case (cur_type)
					lscd_pkg::CMD_CURSOR_POS: begin
						CURSOR_COL <= pay[0][3:0];
						CURSOR_ROW <= pay[1][0];
					end
					lscd_pkg::CMD_CURSOR_STYLE: CURSOR_STYLE <= pay[0][1:0];
					lscd_pkg::CMD_CONTRAST: begin
						// legacy value kept raw; the fine flag tells the driver which scale
						CONTRAST <= (cur_len == lscd_pkg::LEN_ONE) ? pay[0] : pay[1];
						CONTRAST_FINE <= cur_len == lscd_pkg::LEN_TWO;
					end
					lscd_pkg::CMD_BACKLIGHT: begin
						LCD_BL <= pay[0];
						KEY_BL <= (cur_len == lscd_pkg::LEN_ONE) ? pay[0] : pay[1];
					end
					lscd_pkg::CMD_TEMP_MASK: temp_mask <= {pay[3], pay[2], pay[1], pay[0]};
					default: ;
				endcase
			end
		end
	end

	// write and read counters of the memory sequences
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			wcnt <= 4'h0;
			dcnt <= 4'h0;
		end else if (CE) begin
			if (state == lscd_pkg::S_EXEC) begin
				wcnt <= 4'h0;
			end else if (state == lscd_pkg::S_WRITE && !ENUM_WE) begin
				wcnt <= 4'(wcnt + 4'h1);
			end
			if (state == lscd_pkg::S_HDR) begin
				dcnt <= 4'h0;
			end else if (state == lscd_pkg::S_DATA) begin
				dcnt <= 4'(dcnt + 4'h1);
			end
		end
	end

	// write port: enumeration wins, the command write waits while ENUM_WE is high
	always_comb begin
		mem_we = ENUM_WE || state == lscd_pkg::S_WRITE;
		if (ENUM_WE) begin
			mem_waddr = lscd_pkg::ROM_BASE | {1'b0, ENUM_IDX, ENUM_SEL};
			mem_wdata = ENUM_DATA;
		end else if (cur_type == lscd_pkg::CMD_LINE2) begin
			mem_waddr = lscd_pkg::LINE2_BASE | {5'h00, wcnt};
			mem_wdata = pay[wcnt];
		end else begin
			// six bits per row, first byte lands on the top row
			mem_waddr = lscd_pkg::GLYPH_BASE | {3'h0, pay[0][2:0], wcnt[2:0]};
			mem_wdata = pay[4'(wcnt + 4'h1)] & lscd_pkg::GLYPH_ROW_MASK;
		end
	end

	// read port: address code bit 6 picks glyph rows, else chars
	always_comb begin
		if (cur_type == lscd_pkg::CMD_READ_MEM) begin
			read_base = pay[0][6] ? (lscd_pkg::GLYPH_BASE | {3'h0, pay[0][5:0]})
				: {4'h0, pay[0][4:0]};
		end else begin
			read_base = lscd_pkg::ROM_BASE | {1'b0, pay[0][4:0], 3'h0};
		end
		mem_raddr = 9'(read_base + {5'h00, dcnt});
	end

	lscd_byte_ram #(.AW(lscd_pkg::MEM_AW), .DW(8)) u_ram (
		.clk(CLOCK),
		.en(CE),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	// reply header and data bytes
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RSP_START <= 1'b0;
			RSP_TYPE <= 8'h00;
			RSP_LEN <= 5'h00;
			RSP_DATA_VALID <= 1'b0;
			RSP_DATA <= 8'h00;
			rsp_len <= 5'h00;
			err_cnt <= 8'h00;
		end else if (CE) begin
			RSP_START <= state == lscd_pkg::S_HDR;
			RSP_DATA_VALID <= state == lscd_pkg::S_DATA;
			if (state == lscd_pkg::S_EXEC) begin
				// low six bits always echo the command type
				RSP_TYPE <= {exec_ok ? lscd_pkg::RSP_ACK : lscd_pkg::RSP_ERR, cur_type[5:0]};
				rsp_len <= exec_rlen;
				if (!exec_ok) begin
					err_cnt <= 8'(err_cnt + 8'h01);
				end
			end
			if (state == lscd_pkg::S_HDR) begin
				RSP_LEN <= rsp_len;
			end
			if (state == lscd_pkg::S_DATA) begin
				// byte 0 echoes the request, the rest come from the store
				RSP_DATA <= (dcnt == 4'h0) ? pay[0] : mem_rdata;
			end
		end
	end

	// enumeration bookkeeping: family byte marks thermometers
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			present <= 32'h00000000;
			thermo <= 32'h00000000;
		end else if (CE && ENUM_WE && ENUM_SEL == 3'h0) begin
			present[ENUM_IDX] <= 1'b1;
			thermo[ENUM_IDX] <= ENUM_DATA == THERMO_FAMILY_A
				|| ENUM_DATA == THERMO_FAMILY_B;
		end
	end

	// once-per-second tick; eligible sensors drain one per cycle
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tick_cnt <= 32'h00000000;
			pend <= 32'h00000000;
			TEMP_REQ <= 1'b0;
			TEMP_IDX <= 5'h00;
		end else if (CE) begin
			TEMP_REQ <= 1'b0;
			if (tick_cnt == 32'(REPORT_CYCLES - 1)) begin
				tick_cnt <= 32'h00000000;
				// host mask alone is not trusted: wrong families never report
				pend <= temp_mask & thermo;
			end else begin
				tick_cnt <= 32'(tick_cnt + 32'h00000001);
				if (pend != 32'h00000000) begin
					TEMP_REQ <= 1'b1;
					TEMP_IDX <= first_set(pend);
					pend[first_set(pend)] <= 1'b0;
				end
			end
		end
	end

	// APB slave: no wait states, PREADY high in the first access cycle, access taken then
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h00000000;
			PSLVERR <= 1'b0;
			cmd_en <= lscd_pkg::RST_CMD_EN;
		end else if (CE) begin
			PREADY <= PSEL && !PENABLE && !PREADY;
			if (PSEL && !PENABLE) begin
				PSLVERR <= 1'b0;
				case (PADDR)
					lscd_pkg::ADDR_CTRL: PRDATA <= {31'h00000000, cmd_en};
					lscd_pkg::ADDR_STATUS: PRDATA <= {16'h0000, err_cnt, 5'h00, state};
					lscd_pkg::ADDR_SETTINGS: begin
						PRDATA <= {CONTRAST_FINE, CURSOR_STYLE, CURSOR_ROW, CURSOR_COL,
							KEY_BL, LCD_BL, CONTRAST};
					end
					lscd_pkg::ADDR_TEMP_MASK: PRDATA <= temp_mask;
					lscd_pkg::ADDR_PRESENT: PRDATA <= present;
					lscd_pkg::ADDR_THERMO: PRDATA <= thermo;
					default: begin
						PRDATA <= 32'h00000000;
						PSLVERR <= 1'b1;
					end
				endcase
			end
			if (PSEL && PENABLE && PREADY && PWRITE && PADDR == lscd_pkg::ADDR_CTRL) begin
				cmd_en <= PWDATA[0];
			end
		end
	end

	// checks
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST || !CE);
	logic fire;
	assign fire = state == lscd_pkg::S_EXEC;

	a_line_ack: assert property (fire && exec_ok && cur_type == lscd_pkg::CMD_LINE2
		|-> ##[18:40] RSP_START && RSP_TYPE == 8'h48 && RSP_LEN == 5'h00)
		else $error("line write not acknowledged with 0x48");
	a_glyph_slot: assert property (fire && cur_type == lscd_pkg::CMD_GLYPH && pay[0] > 8'h07
		|=> state == lscd_pkg::S_HDR)
		else $error("glyph slot above 7 was written");
	a_glyph_row: assert property (mem_we && !ENUM_WE && cur_type == lscd_pkg::CMD_GLYPH
		|-> mem_wdata[7:6] == 2'h0)
		else $error("glyph row wider than six bits");
	a_cursor_hold: assert property (!$stable({CURSOR_COL, CURSOR_ROW})
		|-> $past(fire && exec_ok && cur_type == lscd_pkg::CMD_CURSOR_POS))
		else $error("cursor moved without a legal position command");
	a_style_ack: assert property (fire && exec_ok && cur_type == lscd_pkg::CMD_CURSOR_STYLE
		|=> ##1 RSP_START && RSP_TYPE == 8'h4C)
		else $error("cursor style not acknowledged");
	a_contrast_fine: assert property (fire && cur_type == lscd_pkg::CMD_CONTRAST
		&& cur_len == 5'h02 |=> CONTRAST == $past(pay[1]) && CONTRAST_FINE)
		else $error("fine contrast not taken from second byte");
	a_bl_both: assert property (fire && exec_ok && cur_type == lscd_pkg::CMD_BACKLIGHT
		&& cur_len == 5'h01 |=> LCD_BL == KEY_BL)
		else $error("single-byte backlight not applied to both");
	a_bl_split: assert property (fire && cur_type == lscd_pkg::CMD_BACKLIGHT
		&& cur_len == 5'h02 |=> LCD_BL == $past(pay[0]) && KEY_BL == $past(pay[1]))
		else $error("two-byte backlight mismatch");
	a_info_len: assert property (fire && exec_ok && cur_type == lscd_pkg::CMD_DEV_INFO
		|=> ##1 RSP_START && RSP_TYPE == 8'h52 && RSP_LEN == 5'h09 ##1 RSP_DATA_VALID [*8])
		else $error("device info reply malformed");
	a_mask_load: assert property (fire && exec_ok && cur_type == lscd_pkg::CMD_TEMP_MASK
		|=> temp_mask == {$past(pay[3]), $past(pay[2]), $past(pay[1]), $past(pay[0])})
		else $error("mask bytes out of order");
	a_temp_ok: assert property (TEMP_REQ |-> thermo[TEMP_IDX])
		else $error("report requested for a non-thermometer");
	a_echo_type: assert property (RSP_START |-> RSP_TYPE[5:0] == cur_type[5:0])
		else $error("reply type does not echo command");
	a_reserved_err: assert property (fire && cur_type inside {8'h0F, 8'h10, 8'h11}
		|=> RSP_TYPE[7:6] == 2'h3 ##1 RSP_START)
		else $error("reserved code not refused");

	c_line: cover property (fire && exec_ok && cur_type == lscd_pkg::CMD_LINE2);
	c_info: cover property (fire && exec_ok && cur_type == lscd_pkg::CMD_DEV_INFO);
	c_error: cover property (fire && !exec_ok);
	c_report: cover property (TEMP_REQ);
endmodule

// file: test/lscd_host_model.sv
// Purpose: host side of the packet link, collects each reply packet
// Assumes: replies stream out with no back-pressure, one byte a cycle
// Notes: done counts whole replies so the bench can wait on it
module lscd_host_model (
	// clock and reset
	input wire logic CLOCK,
	input wire logic SYS_RST,
	// reply stream
	input wire logic RSP_START,
	input wire logic [4:0] RSP_LEN,
	input wire logic RSP_DATA_VALID,
	input wire logic [7:0] RSP_DATA,
	// captured reply
	output logic [7:0] got [16],
	output int n,
	output int done
);
	timeunit 1ns;
	timeprecision 1ps;
	// an empty ack ends on its header, others on their last byte
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			n <= 0;
			done <= 0;
		end else if (RSP_START) begin
			n <= 0;
			if (RSP_LEN == 5'h00) begin
				done <= done + 1;
			end
		end else if (RSP_DATA_VALID) begin
			got[n] <= RSP_DATA;
			n <= n + 1;
			if (n + 1 == int'(RSP_LEN)) begin
				done <= done + 1;
			end
		end
	end
endmodule

// file: test/tb_lscd_decoder.sv
// Purpose: self-checking bench for the command decoder
// Assumes: CE held high, report period cut to 100 cycles
// Notes: packets go in by task, replies land in the host model
module tb_lscd_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] FAM = 8'hA1; // arbitrary thermometer family
	logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, perr, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic cs = 0, dv = 0, cr, rs, rv, fine, crow, bsave, treq, ewe = 0;
	logic [7:0] ct = 8'h00, cd = 8'h00, rt, rdat, con, lbl, kbl, ed = 8'h00;
	logic [4:0] cl = 5'h00, rl, tidx, eidx = 5'h00;
	logic [2:0] esel = 3'h0;
	logic [3:0] ccol;
	logic [1:0] cst;
	logic [7:0] pay [16];
	logic [7:0] got [16];
	int n, done, saves = 0, miscompares = 0, check_count = 0, cycles = 0;
	always #2.5 clock = ~clock;
	lscd_decoder #(.REPORT_CYCLES(100), .THERMO_FAMILY_A(FAM)) uut (.CLOCK(clock),
		.SYS_RST(sys_rst), .CE(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.CMD_START(cs), .CMD_TYPE(ct), .CMD_LEN(cl), .CMD_DATA_VALID(dv), .CMD_DATA(cd),
		.CMD_READY(cr), .RSP_START(rs), .RSP_TYPE(rt), .RSP_LEN(rl), .RSP_DATA_VALID(rv),
		.RSP_DATA(rdat), .ENUM_WE(ewe), .ENUM_IDX(eidx), .ENUM_SEL(esel), .ENUM_DATA(ed),
		.CONTRAST(con), .CONTRAST_FINE(fine), .LCD_BL(lbl), .KEY_BL(kbl), .CURSOR_COL(ccol),
		.CURSOR_ROW(crow), .CURSOR_STYLE(cst), .BOOT_SAVE(bsave), .TEMP_REQ(treq), .TEMP_IDX(tidx));
	lscd_host_model host (.CLOCK(clock), .SYS_RST(sys_rst), .RSP_START(rs), .RSP_LEN(rl),
		.RSP_DATA_VALID(rv), .RSP_DATA(rdat), .got(got), .n(n), .done(done));
	// count save pulses and cut a hang short
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (bsave === 1'b1) saves <= saves + 1;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one packet in; header and each byte held until ready is seen high at an edge
	task automatic cmd(input logic [7:0] t, input int len, input logic [7:0] e);
		int d;
		d = done;
		cs <= 1'b1;
		ct <= t;
		cl <= 5'(len);
		do @(posedge clock); while (cr !== 1'b1);
		cs <= 1'b0;
		for (int i = 0; i < len; i++) begin
			dv <= 1'b1;
			cd <= pay[i];
			do @(posedge clock); while (cr !== 1'b1);
		end
		dv <= 1'b0;
		while (done == d) @(posedge clock);
		check(rt, e);
	endtask
	task automatic go(input logic [7:0] t, input int len, input logic [7:0] b0, b1, e);
		pay[0] = b0;
		pay[1] = b1;
		cmd(t, len, e);
	endtask
	// apb master: request held until pready is seen high at a rising edge,
	// read data taken and the request released at that same edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	initial begin
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		apb(1'b0, 12'h000, 32'h0);
		check(rd, 32'h1);
		// command enable off: ready must drop, then back on for the tests
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		check(rd, 32'h0);
		check(cr, 1'b0);
		apb(1'b1, 12'h000, 32'h1);
		// scan result as enumeration leaves it: eight record bytes for device 0x0B
		for (int s = 0; s < 8; s++) begin
			@(posedge clock);
			ewe <= 1'b1;
			eidx <= 5'h0B;
			esel <= 3'(s);
			ed <= (s == 0) ? FAM : 8'(8'h30 + s);
		end
		@(posedge clock);
		ewe <= 1'b0;
		go(8'h0B, 2, 8'h05, 8'h01, 8'h4B);
		go(8'h0B, 2, 8'h10, 8'h00, 8'hCB);
		go(8'h0B, 2, 8'h03, 8'h02, 8'hCB);
		check({crow, ccol}, 5'h15);
		go(8'h0C, 1, 8'h03, 8'h00, 8'h4C);
		check(cst, 2'h3);
		go(8'h0C, 1, 8'h04, 8'h00, 8'hCC);
		go(8'h0D, 1, 8'hC8, 8'h00, 8'h4D);
		check({fine, con}, 9'h0C8);
		go(8'h0D, 1, 8'hC9, 8'h00, 8'hCD);
		go(8'h0D, 2, 8'hFF, 8'h80, 8'h4D);
		check({fine, con}, 9'h180);
		go(8'h0E, 1, 8'h10, 8'h00, 8'h4E);
		check({lbl, kbl}, 16'h1010);
		go(8'h0E, 2, 8'h11, 8'h22, 8'h4E);
		check({lbl, kbl}, 16'h1122);
		go(8'h0F, 0, 8'h00, 8'h00, 8'hCF);
		go(8'h08, 2, 8'h00, 8'h00, 8'hC8);
		// six refused commands so far, sequencer back in idle
		apb(1'b0, 12'h004, 32'h0);
		check(rd, 32'h00000600);
		apb(1'b0, 12'h008, 32'h0);
		check(rd, 32'hF5221180);
		apb(1'b0, 12'h01C, 32'h0);
		check(perr, 1'b1);
		check(rd, 32'h0);
		for (int i = 0; i < 16; i++) pay[i] = 8'(8'h41 + i);
		cmd(8'h08, 16, 8'h48);
		go(8'h0A, 1, 8'h10, 8'h00, 8'h4A);
		for (int i = 0; i < 9; i++) check(got[i], (i == 0) ? 8'h10 : 8'(8'h40 + i));
		pay[0] = 8'h02;
		for (int i = 1; i < 9; i++) pay[i] = 8'hC0 | 8'(i);
		cmd(8'h09, 9, 8'h49);
		go(8'h0A, 1, 8'h50, 8'h00, 8'h4A);
		for (int i = 1; i < 9; i++) check(got[i], 8'(i));
		go(8'h12, 1, 8'h0B, 8'h00, 8'h52);
		check({rl, got[0], got[1], got[8]}, {5'h09, 8'h0B, FAM, 8'h37});
		pay = '{default: 8'h00};
		pay[1] = 8'h08;
		cmd(8'h13, 4, 8'h53);
		for (int k = 0; k < 400 && treq !== 1'b1; k++) @(posedge clock);
		check({treq, tidx}, 6'h2B);
		go(8'h04, 0, 8'h00, 8'h00, 8'h44);
		check(saves, 1);
		summarize();
	end
endmodule
